//--- hdl/cios_pkg.sv
// package for the control input/output and source select block
// assumes a single 20 MHz clock domain and an AHB-Lite register bus
package cios_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_MODE = 12'h100;
  localparam logic [11:0] ADDR_LNE_CHAN = 12'h108;
  localparam logic [11:0] ADDR_MUX_CHAN = 12'h110;
  localparam logic [11:0] ADDR_PRESCALE = 12'h120;
  localparam logic [11:0] ADDR_CTRL = 12'h124;
  localparam logic [11:0] ADDR_STATUS = 12'h128;
  // reset values
  localparam logic [31:0] MODE_RST = 32'h00000000;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;
  // mode register fields
  localparam int OPM_LSB = 28;
  localparam int OUT_INV_BIT = 23;
  localparam int OUT_MODE_LSB = 20;
  localparam int IN_INV_BIT = 19;
  localparam int IN_MODE_LSB = 16;
  localparam int HS_SRC_BIT = 14;
  localparam int ADD_BIT = 13;
  localparam int SDRAM_BIT = 12;
  localparam int EN_SRC_LSB = 8;
  localparam int LNE_SRC_LSB = 4;
  localparam int FMT_LSB = 2;
  // control register fields
  localparam int CTRL_LED_BIT = 0;
  // operation mode codes
  localparam logic [2:0] OPM_MCS = 3'h2;
  // strobe source codes
  localparam logic [2:0] LSRC_KEY = 3'h0;
  localparam logic [2:0] LSRC_FP = 3'h1;
  localparam logic [2:0] LSRC_PULSER = 3'h2;
  localparam logic [2:0] LSRC_CHAN = 3'h3;
  localparam logic [2:0] LSRC_PRESET = 3'h4;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int PULSER_HZ = 10000000;
  localparam int PULSER_DIV = CLK_HZ / PULSER_HZ;
endpackage

//--- hdl/cios_top.sv
// control input mapping, control output mapping and source selection
// assumes pins are asynchronous and software reaches registers over AHB-Lite
`timescale 1ns/1ns
// Overview of operation
// - input mode 18:16; codes 0,7 inert
// - input invert flips all four inputs
// - mode 1: strobe, user1, user2, strobe block
// - mode 2: strobe, user1, inhibit, strobe block
// - mode 3: strobe, user1, user2, inhibit all
// - mode 4: each input inhibits eight channels
// - mode 5: strobe, histogram scan start
// - mode 6: strobe, inhibit, clear, user1
// - block only front panel, pulser, channel
// - output mode 21:20; out5 strobe/busy, out8 user
// - output invert except monitor channel
// - modes 0,1: empty/threshold, enabled/50 MHz
// - modes 2,3: 10 MHz train, monitor channel
// - user output follows LED bit
// - bit 14 picks key or external scan start
// - FIFO only when bits 13,12 zero
// - add mode with MCS gives histogramming
// - enable source: front panel or channel
// - front panel active in modes 1,2,3,5,6
// - strobe source select, five codes
// - nonzero prescale divides external strobes
// - data format field selects word width
// - selected channel is one of 32 inputs
module cios_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] ctrlInPin,
  input wire logic [31:0] chanPin,
  input wire logic keyStrobe,
  input wire logic presetStrobe,
  input wire logic keyScanStart,
  input wire logic countInProgress,
  input wire logic memEmpty,
  input wire logic memThreshold,
  input wire logic clk50,
  output logic [3:0] ctrlOutPin,
  output logic loadNextEvent,
  output logic enableOut,
  output logic [31:0] inhibitChan,
  output logic clearAll,
  output logic [1:0] userBits,
  output logic scanStart,
  output logic fifoMode,
  output logic histogramMode,
  output logic [1:0] dataFormat
);
  logic rstMeta_r, rstSync_r, rstn;
  logic [31:0] modeReg_r;
  logic [4:0] lneChan_r, muxChan_r;
  logic [15:0] prescale_r, preCnt_r;
  logic ledBit_r;
  logic [3:0] inMeta_r, inSync_r, inPrev_r;
  logic [31:0] chMeta_r, chSync_r;
  logic chPrev_r;
  logic c50Meta_r, c50Sync_r;
  logic pulseCnt_r;
  logic pulserTick;
  logic [3:0] inVal, inRise;
  logic [2:0] inMode, lneSrc, opMode;
  logic [1:0] outMode, enSrc;
  logic fpActive, fpStrobe, fpBlock, chanRise, chanLevel;
  logic extStrobe, extPassed, strobeNxt;
  logic inhAll, scanNxt;
  logic [3:0] outRaw;
  logic monitorSel;
  logic addrPh_r, wrPh_r;
  logic [11:0] addrLat_r;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign rstn = rstSync_r;

  // two-flop synchronisers for all pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inMeta_r <= 4'h0;
      inSync_r <= 4'h0;
      chMeta_r <= 32'h00000000;
      chSync_r <= 32'h00000000;
      c50Meta_r <= 1'b0;
      c50Sync_r <= 1'b0;
    end else begin
      inMeta_r <= ctrlInPin;
      inSync_r <= inMeta_r;
      chMeta_r <= chanPin;
      chSync_r <= chMeta_r;
      c50Meta_r <= clk50;
      c50Sync_r <= c50Meta_r;
    end
  end

  // field decode
  assign inMode = modeReg_r[cios_pkg::IN_MODE_LSB +: 3];
  assign outMode = modeReg_r[cios_pkg::OUT_MODE_LSB +: 2];
  assign lneSrc = modeReg_r[cios_pkg::LNE_SRC_LSB +: 3];
  assign enSrc = modeReg_r[cios_pkg::EN_SRC_LSB +: 2];
  assign opMode = modeReg_r[cios_pkg::OPM_LSB +: 3];
  assign dataFormat = modeReg_r[cios_pkg::FMT_LSB +: 2];

  // optional inversion before interpretation
  assign inVal = inSync_r ^ {4{modeReg_r[cios_pkg::IN_INV_BIT]}};

  // edge history of inverted inputs and selected channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inPrev_r <= 4'h0;
      chPrev_r <= 1'b0;
    end else begin
      inPrev_r <= inVal;
      chPrev_r <= chanLevel;
    end
  end
  assign inRise = inVal & ~inPrev_r;
  assign chanLevel = chSync_r[lneChan_r];
  assign chanRise = chanLevel & ~chPrev_r;

  // input function mapping per mode
  always_comb begin
    fpActive = 1'b0;
    fpBlock = 1'b0;
    inhAll = 1'b0;
    inhibitChan = 32'h00000000;
    clearAll = 1'b0;
    userBits = 2'b00;
    scanNxt = 1'b0;
    case (inMode)
      3'h1: begin
        fpActive = 1'b1;
        userBits = inVal[2:1];
        fpBlock = inVal[3];
      end
      3'h2: begin
        fpActive = 1'b1;
        userBits = {1'b0, inVal[1]};
        inhAll = inVal[2];
        fpBlock = inVal[3];
      end
      3'h3: begin
        fpActive = 1'b1;
        userBits = inVal[2:1];
        inhAll = inVal[3];
      end
      3'h4: begin
        inhibitChan = {{8{inVal[3]}}, {8{inVal[2]}}, {8{inVal[1]}}, {8{inVal[0]}}};
      end
      3'h5: begin
        fpActive = 1'b1;
        scanNxt = inRise[1];
      end
      3'h6: begin
        fpActive = 1'b1;
        inhAll = inVal[1];
        clearAll = inVal[2];
        userBits = {1'b0, inVal[3]};
      end
      default: begin
        fpActive = 1'b0;
      end
    endcase
    if (inhAll) begin
      inhibitChan = 32'hFFFFFFFF;
    end
  end
  assign fpStrobe = fpActive & inRise[0];

  // histogram start: software key or external pulse in mode 5 only
  always_comb begin
    if (modeReg_r[cios_pkg::HS_SRC_BIT]) begin
      scanStart = scanNxt;
    end else begin
      scanStart = keyScanStart;
    end
  end

  // memory mode decode
  assign fifoMode = ~modeReg_r[cios_pkg::ADD_BIT] & ~modeReg_r[cios_pkg::SDRAM_BIT];
  assign histogramMode = modeReg_r[cios_pkg::ADD_BIT] & (opMode == cios_pkg::OPM_MCS);

  // internal 10 MHz pulser enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulseCnt_r <= 1'b0;
    end else begin
      pulseCnt_r <= (pulseCnt_r == 1'(cios_pkg::PULSER_DIV - 1)) ? 1'b0 : pulseCnt_r + 1'b1;
    end
  end
  assign pulserTick = (pulseCnt_r == 1'b0);

  // external strobe source, subject to block input
  always_comb begin
    case (lneSrc)
      cios_pkg::LSRC_FP: extStrobe = fpStrobe;
      cios_pkg::LSRC_PULSER: extStrobe = pulserTick;
      cios_pkg::LSRC_CHAN: extStrobe = chanRise;
      default: extStrobe = 1'b0;
    endcase
  end

  // prescaler passes every (n+1)th external strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preCnt_r <= 16'h0000;
    end else if (extStrobe && !fpBlock && prescale_r != 16'h0000) begin
      preCnt_r <= (preCnt_r >= prescale_r) ? 16'h0000 : preCnt_r + 16'h0001;
    end
  end
  assign extPassed = extStrobe & ~fpBlock & ((prescale_r == 16'h0000) || (preCnt_r >= prescale_r));

  // final strobe; key and preset bypass block and prescaler
  always_comb begin
    case (lneSrc)
      cios_pkg::LSRC_KEY: strobeNxt = keyStrobe;
      cios_pkg::LSRC_FP, cios_pkg::LSRC_PULSER, cios_pkg::LSRC_CHAN: strobeNxt = extPassed | keyStrobe;
      cios_pkg::LSRC_PRESET: strobeNxt = keyStrobe | (presetStrobe && opMode == cios_pkg::OPM_MCS);
      default: strobeNxt = 1'b0;
    endcase
  end

  // registered strobe and enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loadNextEvent <= 1'b0;
      enableOut <= 1'b0;
    end else begin
      loadNextEvent <= strobeNxt;
      case (enSrc)
        2'h0: enableOut <= fpActive & inVal[0];
        2'h1: enableOut <= chanLevel;
        default: enableOut <= 1'b0;
      endcase
    end
  end

  // control outputs 5 to 8
  always_comb begin
    outRaw[0] = (opMode == cios_pkg::OPM_MCS) ? countInProgress : loadNextEvent;
    outRaw[3] = ledBit_r;
    monitorSel = 1'b0;
    case (outMode)
      2'h0: begin
        outRaw[1] = memEmpty;
        outRaw[2] = memThreshold;
      end
      2'h1: begin
        outRaw[1] = enableOut;
        outRaw[2] = c50Sync_r;
      end
      2'h2: begin
        outRaw[1] = pulserTick;
        outRaw[2] = pulserTick;
      end
      default: begin
        outRaw[1] = pulserTick;
        outRaw[2] = chSync_r[muxChan_r];
        monitorSel = 1'b1;
      end
    endcase
  end

  // registered output pins with inversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlOutPin <= 4'h0;
    end else begin
      ctrlOutPin[0] <= outRaw[0] ^ modeReg_r[cios_pkg::OUT_INV_BIT];
      ctrlOutPin[1] <= outRaw[1] ^ modeReg_r[cios_pkg::OUT_INV_BIT];
      ctrlOutPin[2] <= outRaw[2] ^ (modeReg_r[cios_pkg::OUT_INV_BIT] & ~monitorSel);
      ctrlOutPin[3] <= outRaw[3] ^ modeReg_r[cios_pkg::OUT_INV_BIT];
    end
  end

  // AHB-Lite address phase capture, zero wait state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrPh_r <= 1'b0;
      wrPh_r <= 1'b0;
      addrLat_r <= 12'h000;
    end else if (hready) begin
      addrPh_r <= hsel & htrans[1];
      wrPh_r <= hsel & htrans[1] & hwrite;
      addrLat_r <= haddr[11:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modeReg_r <= cios_pkg::MODE_RST;
      lneChan_r <= cios_pkg::CHAN_RST;
      muxChan_r <= cios_pkg::CHAN_RST;
      prescale_r <= cios_pkg::PRESCALE_RST;
      ledBit_r <= 1'b0;
    end else if (wrPh_r) begin
      case (addrLat_r)
        cios_pkg::ADDR_MODE: modeReg_r <= hwdata;
        cios_pkg::ADDR_LNE_CHAN: lneChan_r <= hwdata[4:0];
        cios_pkg::ADDR_MUX_CHAN: muxChan_r <= hwdata[4:0];
        cios_pkg::ADDR_PRESCALE: prescale_r <= hwdata[15:0];
        cios_pkg::ADDR_CTRL: ledBit_r <= hwdata[cios_pkg::CTRL_LED_BIT];
        default: ;
      endcase
    end
  end

  // read data registered at the address phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        cios_pkg::ADDR_MODE: hrdata <= modeReg_r;
        cios_pkg::ADDR_LNE_CHAN: hrdata <= {27'h0000000, lneChan_r};
        cios_pkg::ADDR_MUX_CHAN: hrdata <= {27'h0000000, muxChan_r};
        cios_pkg::ADDR_PRESCALE: hrdata <= {16'h0000, prescale_r};
        cios_pkg::ADDR_CTRL: hrdata <= {31'h00000000, ledBit_r};
        cios_pkg::ADDR_STATUS: hrdata <= {24'h000000, fifoMode, histogramMode, enableOut, inVal, 1'b0};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // strobe never issued for a reserved source code
  a_reserved_src: assert property (@(posedge clk) disable iff (!rstn)
    (lneSrc > cios_pkg::LSRC_PRESET) |=> !loadNextEvent) else $error("strobe on reserved source");
  // mode 4 grouped inhibit
  a_group_inhibit: assert property (@(posedge clk) disable iff (!rstn)
    (inMode == 3'h4) |-> inhibitChan[7:0] == {8{inVal[0]}} && inhibitChan[31:24] == {8{inVal[3]}})
    else $error("group inhibit wrong");
  // inert modes
  a_inert_mode: assert property (@(posedge clk) disable iff (!rstn)
    (inMode == 3'h0 || inMode == 3'h7) |-> inhibitChan == 32'h0 && !clearAll && userBits == 2'b00)
    else $error("inert mode acts");
  // memory mode
  a_fifo_mode: assert property (@(posedge clk) disable iff (!rstn)
    fifoMode == ({modeReg_r[cios_pkg::ADD_BIT], modeReg_r[cios_pkg::SDRAM_BIT]} == 2'b00))
    else $error("fifo mode wrong");
  // blocked front panel strobe
  a_strobe_block: assert property (@(posedge clk) disable iff (!rstn)
    (lneSrc == cios_pkg::LSRC_FP && fpBlock && !keyStrobe) |=> !loadNextEvent)
    else $error("blocked strobe passed");
  // user output tracks led bit
  a_user_out: assert property (@(posedge clk) disable iff (!rstn)
    ##1 ctrlOutPin[3] == ($past(ledBit_r) ^ $past(modeReg_r[cios_pkg::OUT_INV_BIT])))
    else $error("user output wrong");
  // monitor channel never inverted
  a_monitor_raw: assert property (@(posedge clk) disable iff (!rstn)
    (outMode == 2'h3) |=> ctrlOutPin[2] == $past(chSync_r[muxChan_r])) else $error("monitor inverted");
  // external scan start needs mode 5
  a_scan_mode5: assert property (@(posedge clk) disable iff (!rstn)
    (modeReg_r[cios_pkg::HS_SRC_BIT] && inMode != 3'h5) |-> !scanStart)
    else $error("scan start outside mode 5");
  // key strobe passes for source codes 0 to 4 (key through preset)
  a_key_bypass: assert property (@(posedge clk) disable iff (!rstn)
    (keyStrobe && lneSrc <= cios_pkg::LSRC_PRESET) |=> loadNextEvent) else $error("key strobe lost");
endmodule // cios_top

//--- verification/cios_ext_model.sv
// far-side electronics: drives the four control inputs, watches output 5 only
// assumes the bench commands the input levels and reads the output 5 pulse count
`timescale 1ns/1ns
module cios_ext_model (
  input wire logic clk,
  input wire logic [3:0] level,
  input wire logic [3:0] ctrlOutPin,
  output logic [3:0] ctrlInPin,
  output logic [15:0] out5Count
);
  logic out5Last;
  initial out5Count = 16'h0000;
  // inputs change just after the edge, as real pins would
  always @(posedge clk) begin
    ctrlInPin <= level;
  end
  // count rising edges seen on output 5
  always @(posedge clk) begin
    out5Last <= ctrlOutPin[0];
    if (ctrlOutPin[0] === 1'b1 && out5Last === 1'b0) begin
      out5Count <= out5Count + 16'h0001;
    end
  end
endmodule // cios_ext_model

//--- verification/testbench.sv
// self-checking bench for the control pin mapping and source select block
// assumes one 20 MHz clock, an AHB-Lite master in the bench, the pin model beside it
`timescale 1ns/1ns
`define CHK(a, e) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, inhibitChan, rd;
  logic hreadyout, hresp, loadNextEvent, enableOut, clearAll, scanStart;
  logic fifoMode, histogramMode;
  logic [1:0] userBits, dataFormat;
  logic [3:0] ctrlInPin, ctrlOutPin, level = 4'h0, p;
  logic [31:0] chanPin = 32'h0;
  logic keyStrobe = 1'b0, presetStrobe = 1'b0, keyScanStart = 1'b0;
  logic countInProgress = 1'b0, memEmpty = 1'b0, memThreshold = 1'b0, clk50 = 1'b0;
  logic [15:0] out5Count;
  int num_errors = 0, tests_run = 0, cyc = 0, lneCnt = 0, scCnt = 0, hi6 = 0, hi7 = 0, c;
  cios_top dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ctrlInPin(ctrlInPin), .chanPin(chanPin),
    .keyStrobe(keyStrobe), .presetStrobe(presetStrobe), .keyScanStart(keyScanStart),
    .countInProgress(countInProgress), .memEmpty(memEmpty), .memThreshold(memThreshold),
    .clk50(clk50), .ctrlOutPin(ctrlOutPin), .loadNextEvent(loadNextEvent),
    .enableOut(enableOut), .inhibitChan(inhibitChan), .clearAll(clearAll),
    .userBits(userBits), .scanStart(scanStart), .fifoMode(fifoMode),
    .histogramMode(histogramMode), .dataFormat(dataFormat));
  cios_ext_model ext (.clk(clk), .level(level), .ctrlOutPin(ctrlOutPin),
    .ctrlInPin(ctrlInPin), .out5Count(out5Count));
  // clock and cycle ceiling
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  // count strobes, scan starts and high cycles of outputs 6 and 7
  always @(posedge clk) begin
    if (loadNextEvent === 1'b1) lneCnt <= lneCnt + 1;
    if (scanStart === 1'b1) scCnt <= scCnt + 1;
    if (ctrlOutPin[1] === 1'b1) hi6 <= hi6 + 1;
    if (ctrlOutPin[2] === 1'b1) hi7 <= hi7 + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one single AHB-Lite word transfer, address then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic mode(input logic [31:0] v);
    bus(1'b1, cios_pkg::ADDR_MODE, v);
    tick(6);
  endtask
  task automatic key();
    keyStrobe <= 1'b1;
    @(posedge clk);
    keyStrobe <= 1'b0;
    tick(4);
  endtask
  task automatic pin(input logic [3:0] hi, input logic [3:0] lo, input int n);
    level <= hi;
    tick(n);
    level <= lo;
    tick(6);
  endtask
  // expected {clear, user bits, channel inhibits} for one input mode and level set
  function automatic logic [34:0] expIn(input logic [2:0] m, input logic [3:0] q);
    logic [34:0] e;
    e = 35'h0;
    case (m)
      3'h1: e[33:32] = q[2:1];
      3'h2: e = {2'h0, q[1], {32{q[2]}}};
      3'h3: e = {1'b0, q[2:1], {32{q[3]}}};
      3'h4: e[31:0] = {{8{q[3]}}, {8{q[2]}}, {8{q[1]}}, {8{q[0]}}};
      3'h6: e = {q[2], 1'b0, q[3], {32{q[1]}}};
      default: e = 35'h0;
    endcase
    return e;
  endfunction
  task results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    arst_n <= 1'b1;
    tick(3);
    `CHK(fifoMode, 1'b1)
    bus(1'b0, cios_pkg::ADDR_MODE, 32'h0);
    `CHK(rd, cios_pkg::MODE_RST)
    `CHK({hreadyout, hresp}, 2'h2)
    bus(1'b0, 12'h0FC, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 32; i++) begin
      p = i[1] ? 4'h5 : 4'hA;
      level <= p ^ {4{i[0]}};
      mode({12'h000, i[0], i[4:2], 16'h0000});
      `CHK({clearAll, userBits, inhibitChan}, expIn(i[4:2], p))
    end
    level <= 4'h0;
    mode(32'h00010010);
    c = lneCnt;
    p = out5Count[3:0];
    pin(4'h1, 4'h0, 4);
    `CHK(lneCnt - c, 1)
    `CHK(out5Count[3:0] - p, 4'h1)
    pin(4'h8, 4'h8, 1);
    c = lneCnt;
    pin(4'h9, 4'h8, 4);
    key();
    `CHK(lneCnt - c, 1)
    mode(32'h00010020);
    c = lneCnt;
    tick(40);
    `CHK(lneCnt - c, 0)
    level <= 4'h0;
    mode(32'h00010000);
    c = lneCnt;
    pin(4'h1, 4'h0, 2);
    key();
    `CHK(lneCnt - c, 1)
    for (int s = 5; s < 8; s++) begin
      mode({24'h000000, s[3:0], 4'h0});
      c = lneCnt;
      key();
      `CHK(lneCnt - c, 0)
    end
    mode(32'h00000020);
    c = lneCnt;
    tick(40);
    `CHK((lneCnt - c) inside {[19:21]}, 1'b1)
    bus(1'b1, cios_pkg::ADDR_PRESCALE, 32'h2);
    c = lneCnt;
    tick(60);
    `CHK((lneCnt - c) inside {[9:11]}, 1'b1)
    mode(32'h00000000);
    c = lneCnt;
    key();
    key();
    key();
    `CHK(lneCnt - c, 3)
    bus(1'b1, cios_pkg::ADDR_PRESCALE, 32'h0);
    bus(1'b1, cios_pkg::ADDR_LNE_CHAN, 32'h5);
    mode(32'h00000030);
    c = lneCnt;
    chanPin <= 32'h1;
    tick(4);
    chanPin <= 32'h20;
    @(posedge clk);
    chanPin <= 32'h0;
    tick(6);
    `CHK(lneCnt - c, 1)
    mode(32'h00000040);
    c = lneCnt;
    presetStrobe <= 1'b1;
    @(posedge clk);
    presetStrobe <= 1'b0;
    tick(4);
    `CHK(lneCnt - c, 0)
    mode(32'h20000040);
    c = lneCnt;
    presetStrobe <= 1'b1;
    @(posedge clk);
    presetStrobe <= 1'b0;
    countInProgress <= 1'b1;
    tick(4);
    `CHK(lneCnt - c, 1)
    `CHK(ctrlOutPin[0], 1'b1)
    level <= 4'h1;
    chanPin <= 32'h20;
    mode(32'h00010000);
    `CHK(enableOut, 1'b1)
    bus(1'b0, cios_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h000000A2)
    mode(32'h00040000);
    `CHK(enableOut, 1'b0)
    mode(32'h00000100);
    `CHK(enableOut, 1'b1)
    mode(32'h00000200);
    `CHK(enableOut, 1'b0)
    memEmpty <= 1'b1;
    clk50 <= 1'b1;
    bus(1'b1, cios_pkg::ADDR_CTRL, 32'h1);
    mode(32'h00000000);
    `CHK(ctrlOutPin, 4'hA)
    mode(32'h00800000);
    `CHK(ctrlOutPin, 4'h5)
    mode(32'h00100000);
    `CHK(ctrlOutPin, 4'hC)
    mode(32'h00200000);
    c = hi6;
    p = hi7[3:0];
    tick(20);
    `CHK(hi6 - c, 10)
    `CHK(hi7[3:0] - p, 4'hA)
    bus(1'b1, cios_pkg::ADDR_MUX_CHAN, 32'h3);
    chanPin <= 32'h8;
    mode(32'h00300000);
    `CHK(ctrlOutPin[3:2], 2'h3)
    mode(32'h00B00000);
    `CHK(ctrlOutPin[3:2], 2'h1)
    mode(32'h00000000);
    c = scCnt;
    keyScanStart <= 1'b1;
    @(posedge clk);
    keyScanStart <= 1'b0;
    level <= 4'h0;
    mode(32'h00054000);
    pin(4'h2, 4'h0, 1);
    keyScanStart <= 1'b1;
    @(posedge clk);
    keyScanStart <= 1'b0;
    mode(32'h00014000);
    pin(4'h2, 4'h0, 1);
    `CHK(scCnt - c, 2)
    for (int i = 0; i < 8; i++) begin
      mode({1'b0, i[2] ? 3'h2 : 3'h0, 14'h0, i[1:0], 8'h00, i[1:0], 2'h0});
      `CHK({fifoMode, histogramMode, dataFormat}, {i[1:0] == 2'h0, i[1] & i[2], i[1:0]})
    end
    results();
  end
endmodule // testbench
